/* sensor_talkback_interrogator.sv */
/*
 * Talkback interrogator: holding registers at the host side, command
 * strobe and reply bytes at the decoder line side.
 * Assumes a framing layer turns host messages into register
 * accesses, and a line transmitter and receiver on the same clock.
 */
`timescale 1ns/10ps
`include "talkback_consts.svh"
module sensor_talkback_interrogator
   import talkback_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = `TALK_TIMEOUT_MS * `CLK_KHZ,
   parameter int unsigned TMR_W = 26
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   output logic reg_ack_out,
   output logic tx_start_out,
   output logic [2:0] tx_cmd_out,
   output logic [6:0] tx_addr_out,
   input wire logic rx_byte_valid_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic step_valid_in,
   input wire logic [15:0] step_ma_in,
   input wire logic desired_req_in,
   output logic desired_go_out,
   output logic busy_out,
   output logic [3:0] ptr_field_out
);

   // ==========================================================
   // Pointer decode, used by the read mux and the field output
   function automatic ptr_field_t field_of(input logic [5:0] p);
      if (p < `PTR_TEXT1) field_of = PF_POSITION;
      else if (p < `PTR_TEXT2) field_of = PF_TEXT1;
      else if (p < `PTR_SERIAL) field_of = PF_TEXT2;
      else if (p < `PTR_TIME) field_of = PF_SERIAL;
      else if (p < `PTR_DATE) field_of = PF_TIME;
      else if (p < `PTR_PIN) field_of = PF_DATE;
      else if (p < `PTR_VER) field_of = PF_PIN;
      else if (p == `PTR_VER) field_of = PF_VERSION;
      else field_of = PF_BEYOND;
   endfunction

   // ==========================================================
   // Declarations
   talk_state_t state_r;
   logic [15:0] target_r;
   logic [15:0] trig_r;
   logic armed_r;
   logic [15:0] thresh_r;
   logic good_r;
   logic noreply_r;
   logic fail_r;
   logic [5:0] ptr_r;
   logic [TMR_W-1:0] timer_r;
   logic rd_pend_r;
   logic [7:0] rd_addr_r;
   logic desired_pend_r;
   logic [2:0] cmd_r;
   logic word_valid;
   logic [15:0] word;
   logic [15:0] step_ma;
   logic step_event;
   logic step_over;
   logic idle;
   logic start_ok;
   logic done_good;
   logic done_none;
   logic wr_target;
   logic wr_trig;
   logic wr_status;
   logic wr_thresh;
   logic [15:0] status_word;
   logic [15:0] rdata_nxt;

   assign idle = (state_r == ST_IDLE);
   assign start_ok = idle && armed_r && (trig_r == `TRIG_ALL_ONES) && (target_r != `ZERO16);
   assign done_good = (state_r == ST_WAIT) && word_valid;
   assign done_none = (state_r == ST_WAIT) && !word_valid && (timer_r == '0);
   // Target and trigger are frozen while busy so one talkback is outstanding
   assign wr_target = reg_wr_in && (reg_addr_in == `REG_TARGET) && idle;
   assign wr_trig = reg_wr_in && (reg_addr_in == `REG_TRIG) && idle;
   assign wr_status = reg_wr_in && (reg_addr_in == `REG_STATUS);
   assign wr_thresh = reg_wr_in && (reg_addr_in == `REG_THRESH);

   // ==========================================================
   // Sub-blocks
   reply_assembler u_reply (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .clear_in(state_r == ST_SEND),
      .byte_valid_in(rx_byte_valid_in && (state_r == ST_WAIT)),
      .byte_in(rx_byte_in),
      .word_valid_out(word_valid),
      .word_out(word)
   );

   step_checker u_step (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .step_valid_in(step_valid_in),
      .step_ma_in(step_ma_in),
      .thresh_in(thresh_r),
      .step_ma_out(step_ma),
      .event_out(step_event),
      .over_out(step_over)
   );

   // ==========================================================
   // Interrogation sequencer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= ST_IDLE;
         timer_r <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start_ok) begin
                  state_r <= ST_SEND;
               end
            end
            ST_SEND: begin
               state_r <= ST_WAIT;
               timer_r <= TMR_W'(TIMEOUT_CYC);
            end
            ST_WAIT: begin
               timer_r <= timer_r - 1'b1;
               if (done_good || done_none) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Line command strobe
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tx_start_out <= 1'b0;
         tx_cmd_out <= `CMD_OFF;
         tx_addr_out <= 7'h00;
         cmd_r <= `CMD_OFF;
      end else begin
         tx_start_out <= (state_r == ST_SEND);
         if (state_r == ST_SEND) begin
            tx_cmd_out <= target_r[10:8];
            tx_addr_out <= target_r[6:0];
            cmd_r <= target_r[10:8];
         end
      end
   end

   // ==========================================================
   // Holding registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         target_r <= `ZERO16;
         thresh_r <= `THRESH_RESET;
      end else begin
         if (wr_target) begin
            target_r <= reg_wdata_in;
         end
         if (wr_thresh) begin
            thresh_r <= reg_wdata_in;
         end
      end
   end

   // Only a host write arms a start: a reply that is itself all ones
   // (closed contact, count at its top) must not launch another talkback
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         armed_r <= 1'b0;
      end else if (start_ok) begin
         armed_r <= 1'b0;
      end else if (wr_trig) begin
         armed_r <= (reg_wdata_in == `TRIG_ALL_ONES);
      end
   end

   // The reply word is passed on untouched: the decoder type decides its meaning
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         trig_r <= `ZERO16;
      end else if (done_good) begin
         trig_r <= word;
      end else if (done_none) begin
         trig_r <= `RESULT_NONE;
      end else if (wr_trig) begin
         trig_r <= reg_wdata_in;
      end
   end

   // ==========================================================
   // Status flags; completion wins over a host write in the same cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         good_r <= 1'b0;
         noreply_r <= 1'b0;
         fail_r <= 1'b0;
      end else begin
         if (done_good || done_none) begin
            good_r <= done_good;
            noreply_r <= done_none;
         end else if (wr_status) begin
            good_r <= reg_wdata_in[`ST_BIT_GOOD];
            noreply_r <= reg_wdata_in[`ST_BIT_NOREPLY];
         end
         if (step_event) begin
            fail_r <= step_over;
         end else if (wr_status) begin
            fail_r <= reg_wdata_in[`ST_BIT_FAIL];
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= !idle || start_ok;
      end
   end

   // ==========================================================
   // Mirror of the addressed decoder's return pointer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ptr_r <= 6'h00;
         ptr_field_out <= PF_POSITION;
      end else begin
         if ((state_r == ST_SEND) && (target_r[10:8] == `CMD_ASK4)) begin
            ptr_r <= 6'h00;
         end else if (done_good && (cmd_r == `CMD_ASK3)) begin
            ptr_r <= ptr_r + 6'h01;
         end
         ptr_field_out <= field_of(ptr_r);
      end
   end

   // ==========================================================
   // Desired-output changes are held until the line is free
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         desired_pend_r <= 1'b0;
         desired_go_out <= 1'b0;
      end else begin
         desired_go_out <= 1'b0;
         if (desired_req_in || desired_pend_r) begin
            if (idle && !start_ok) begin
               desired_go_out <= 1'b1;
               desired_pend_r <= 1'b0;
            end else begin
               desired_pend_r <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Host access answers; reads wait out a running talkback
   always_comb begin
      status_word = `ZERO16;
      status_word[`ST_BIT_BUSY] = busy_out;
      status_word[`ST_BIT_FAIL] = fail_r;
      status_word[`ST_BIT_GOOD] = good_r;
      status_word[`ST_BIT_NOREPLY] = noreply_r;
      unique case (rd_addr_r)
         `REG_STATUS: rdata_nxt = status_word;
         `REG_THRESH: rdata_nxt = thresh_r;
         `REG_TARGET: rdata_nxt = target_r;
         `REG_TRIG: rdata_nxt = trig_r;
         `REG_STEP: rdata_nxt = step_ma;
         `REG_PTR: rdata_nxt = {6'h00, 4'(field_of(ptr_r)), ptr_r};
         default: rdata_nxt = `ZERO16;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= 8'h00;
         reg_ack_out <= 1'b0;
         reg_rdata_out <= `ZERO16;
      end else begin
         reg_ack_out <= reg_wr_in;
         if (reg_rd_in) begin
            rd_pend_r <= 1'b1;
            rd_addr_r <= reg_addr_in;
         end else if (rd_pend_r && idle) begin
            rd_pend_r <= 1'b0;
            reg_ack_out <= 1'b1;
            reg_rdata_out <= rdata_nxt;
         end
      end
   end

   // ==========================================================
   // Checks
   logic [TMR_W:0] busy_cnt_r;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_cnt_r <= '0;
      end else begin
         busy_cnt_r <= idle ? '0 : busy_cnt_r + 1'b1;
      end
   end

   chk_start_cond: assert property (@(posedge clk_in) disable iff (rst_in)
      start_ok |=> (state_r == ST_SEND) ##1 tx_start_out)
      else $error("talkback did not start");
   chk_result_good: assert property (@(posedge clk_in) disable iff (rst_in)
      done_good |=> (trig_r == $past(word)) && good_r && !noreply_r)
      else $error("good reply not published");
   chk_result_none: assert property (@(posedge clk_in) disable iff (rst_in)
      done_none |=> (trig_r == `RESULT_NONE) && noreply_r && !good_r)
      else $error("missing reply not published");
   chk_busy_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      busy_cnt_r <= (TMR_W + 1)'(TIMEOUT_CYC + 2))
      else $error("talkback exceeded its timeout");
   chk_trig_kept: assert property (@(posedge clk_in) disable iff (rst_in)
      (state_r == ST_WAIT) && !done_good && !done_none |=> trig_r == `TRIG_ALL_ONES)
      else $error("trigger value lost before result");
   chk_desired_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      desired_go_out |-> $past(idle) && $past(!start_ok))
      else $error("desired change released during talkback");
   chk_tx_cmd: assert property (@(posedge clk_in) disable iff (rst_in)
      tx_start_out |-> (tx_cmd_out == $past(target_r[10:8])) && (tx_addr_out == $past(target_r[6:0])))
      else $error("command sent differs from target");
   chk_ptr_reset: assert property (@(posedge clk_in) disable iff (rst_in)
      tx_start_out && (tx_cmd_out == `CMD_ASK4) |-> ptr_r == 6'h00)
      else $error("pointer not reset by command seven");
   chk_result_rearm: assert property (@(posedge clk_in) disable iff (rst_in)
      (done_good || done_none) |=> !start_ok)
      else $error("result value restarted a talkback");
   chk_read_wait: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_pend_r && !idle && !reg_wr_in |=> !reg_ack_out)
      else $error("read answered during talkback");

endmodule // sensor_talkback_interrogator

/* talkback_consts.svh */
/*
 * Holds the shared constants of the talkback interrogator: register
 * offsets, status bit positions, reset values, command codes, timing.
 * Assumes it is included by bare name before the package and modules.
 */
// What this block does
// - Three-bit decoder command codes, asks are 4-7
// - All-ones trigger plus non-zero target starts talkback
// - Result overwrites trigger: reply word, else zeros
// - Good reply sets good flag, clears no-reply
// - Busy flag held during talkback, ends within second
// - Host poll answers may wait until talkback ends
// - All-ones stays until the result replaces it
// - Desired output changes wait for talkback end
// - Command 5 turns loop excitation on, returns 1
// - Command 4 gives 15-bit count plus contact
// - Command 4 gives scaled loop reading, excitation off
// - Command 7 gives volts high, solenoid state low
// - Command 7 resets the return pointer to zero
// - Command 6 returns pointed word, then increments
// - Pointer values map to position, text, serial, time
// - Replies are 16-bit words, high byte first
// - Acknowledge current step published in milliamps
// - Step above upper threshold flags switching failure
`ifndef TALKBACK_CONSTS_SVH
`define TALKBACK_CONSTS_SVH

// ==========================================================
// Register offsets
`define REG_STATUS 8'h00
`define REG_THRESH 8'h02
`define REG_TARGET 8'h18
`define REG_TRIG 8'h19
`define REG_STEP 8'h1a
`define REG_PTR 8'h1b

// ==========================================================
// Status bits and values
`define ST_BIT_BUSY 0
`define ST_BIT_FAIL 7
`define ST_BIT_GOOD 12
`define ST_BIT_NOREPLY 14
`define TRIG_ALL_ONES 16'hffff
`define RESULT_NONE 16'h0000
`define THRESH_RESET 16'h038e
`define ZERO16 16'h0000

// ==========================================================
// Decoder commands
`define CMD_OFF 3'h0
`define CMD_ON 3'h1
`define CMD_RSVD 3'h2
`define CMD_CAL 3'h3
`define CMD_ASK1 3'h4
`define CMD_ASK2 3'h5
`define CMD_ASK3 3'h6
`define CMD_ASK4 3'h7

// ==========================================================
// Return pointer field starts
`define PTR_TEXT1 6'h04
`define PTR_TEXT2 6'h10
`define PTR_SERIAL 6'h1c
`define PTR_TIME 6'h1d
`define PTR_DATE 6'h1f
`define PTR_PIN 6'h21
`define PTR_VER 6'h22

// ==========================================================
// Timing
`define TALK_TIMEOUT_MS 1000
`define CLK_KHZ 50000

`endif

/* talkback_pkg.sv */
/*
 * Types shared by the talkback interrogator modules.
 * Assumes talkback_consts.svh is compiled alongside.
 */
package talkback_pkg;

   // ==========================================================
   // Interrogation sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEND = 3'b010,
      ST_WAIT = 3'b100
   } talk_state_t;

   // ==========================================================
   // What the mirrored return pointer selects
   typedef enum logic [3:0] {
      PF_POSITION = 4'h0,
      PF_TEXT1 = 4'h1,
      PF_TEXT2 = 4'h2,
      PF_SERIAL = 4'h3,
      PF_TIME = 4'h4,
      PF_DATE = 4'h5,
      PF_PIN = 4'h6,
      PF_VERSION = 4'h7,
      PF_BEYOND = 4'h8
   } ptr_field_t;

endpackage

/* reply_assembler.sv */
/*
 * Pairs reply bytes from the line receiver into 16-bit words.
 * Assumes bytes arrive on the same clock, high byte first.
 */
`timescale 1ns/10ps
module reply_assembler (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clear_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   output logic word_valid_out,
   output logic [15:0] word_out
);

   logic have_hi_r;
   logic [7:0] hi_r;

   // An odd byte left over is dropped by the next clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         have_hi_r <= 1'b0;
         hi_r <= 8'h00;
         word_out <= 16'h0000;
         word_valid_out <= 1'b0;
      end else begin
         word_valid_out <= 1'b0;
         if (clear_in) begin
            have_hi_r <= 1'b0;
         end else if (byte_valid_in) begin
            if (!have_hi_r) begin
               hi_r <= byte_in;
               have_hi_r <= 1'b1;
            end else begin
               word_out <= {hi_r, byte_in};
               word_valid_out <= 1'b1;
               have_hi_r <= 1'b0;
            end
         end
      end
   end

endmodule // reply_assembler

/* step_checker.sv */
/*
 * Captures the acknowledge current step and compares it with the
 * upper threshold. Assumes the measurement arrives as a one-cycle
 * strobe on the same clock.
 */
`timescale 1ns/10ps
module step_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic step_valid_in,
   input wire logic [15:0] step_ma_in,
   input wire logic [15:0] thresh_in,
   output logic [15:0] step_ma_out,
   output logic event_out,
   output logic over_out
);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         step_ma_out <= 16'h0000;
         event_out <= 1'b0;
         over_out <= 1'b0;
      end else begin
         event_out <= step_valid_in;
         if (step_valid_in) begin
            step_ma_out <= step_ma_in;
            over_out <= (step_ma_in > thresh_in);
         end
      end
   end

   chk_step_over: assert property (@(posedge clk_in) disable iff (rst_in)
      step_valid_in && (step_ma_in > thresh_in) |=>
      event_out && over_out && (step_ma_out == $past(step_ma_in)))
      else $error("step above threshold not flagged");

endmodule // step_checker

/* decoder_model.sv */
/* Behavioural field decoder on the talkback line.
   Assumes the command strobe and the reply bytes share one clock. */
`timescale 1ns/10ps
module decoder_model (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic [2:0] cmd_in,
   input wire logic [6:0] addr_in,
   input wire logic mute_in,
   input wire logic [7:0] delay_in,
   output logic byte_valid_out,
   output logic [7:0] byte_out
);
   logic [7:0] ptr_r [128];
   logic [14:0] cnt_r = 15'h7ffe;
   logic [15:0] word;
   initial begin
      byte_valid_out = 1'b0;
      byte_out = 8'h5a;
      foreach (ptr_r[i]) begin
         ptr_r[i] = 8'h00;
      end
   end
   // ==========================================================
   // Reply; a muted decoder never heard the command, so it keeps its pointer
   always @(posedge clk_in) begin
      if (start_in === 1'b1 && !mute_in) begin
         case (cmd_in)
            3'h4: begin
               word = {1'b1, cnt_r};
               cnt_r = cnt_r + 15'h0001;
            end
            3'h5: word = 16'h0001;
            3'h6: begin
               word = {1'b0, addr_in, ptr_r[addr_in]};
               ptr_r[addr_in] = ptr_r[addr_in] + 8'h01;
            end
            default: begin
               word = 16'h1801;
               ptr_r[addr_in] = 8'h00;
            end
         endcase
         repeat (delay_in) @(posedge clk_in);
         // Idle line shows the inverse so a stale byte never passes as data
         for (int b = 1; b >= 0; b--) begin
            byte_out <= word[b*8 +: 8];
            byte_valid_out <= 1'b1;
            @(posedge clk_in);
            byte_out <= ~word[b*8 +: 8];
            byte_valid_out <= 1'b0;
            @(posedge clk_in);
         end
      end
   end
endmodule // decoder_model

/* tb.sv */
/* Self-checking bench for the talkback interrogator with a reference model.
   Assumes the design files and decoder_model.sv are compiled first. */
`timescale 1ns/10ps
`include "talkback_consts.svh"
module tb;
   import talkback_pkg::*;
   localparam int unsigned TMO = 200;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic step_v = 1'b0;
   logic [15:0] step_ma = 16'h0000;
   logic des_req = 1'b0;
   logic mute = 1'b0;
   logic [7:0] delay = 8'h00;
   logic ack, tx_start, rx_v, des_go, busy;
   logic [15:0] rdata, q;
   logic [2:0] tx_cmd, exp_cmd;
   logic [6:0] tx_addr, exp_addr;
   logic [7:0] rx_b;
   logic [3:0] pfield;
   logic [15:0] steps [4] = '{16'h010e, 16'h038e, 16'h038f, 16'h0000};
   int failures = 0;
   int cmp_count = 0;
   int starts = 0;
   int gos = 0;
   int exp_ptr [128] = '{default: 0};
   int exp_cnt = 32'h7ffe;

   always #10 clk_in = ~clk_in;

   sensor_talkback_interrogator #(.TIMEOUT_CYC(TMO)) dut (.clk_in(clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata), .reg_ack_out(ack),
      .tx_start_out(tx_start), .tx_cmd_out(tx_cmd), .tx_addr_out(tx_addr),
      .rx_byte_valid_in(rx_v), .rx_byte_in(rx_b), .step_valid_in(step_v),
      .step_ma_in(step_ma), .desired_req_in(des_req), .desired_go_out(des_go),
      .busy_out(busy), .ptr_field_out(pfield));

   decoder_model decoder (.clk_in(clk_in), .start_in(tx_start), .cmd_in(tx_cmd),
      .addr_in(tx_addr), .mute_in(mute), .delay_in(delay), .byte_valid_out(rx_v),
      .byte_out(rx_b));

   // ==========================================================
   // Compare and report
   task automatic check_word(input string what, input logic [15:0] e, input logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic check_flag(input string what, input logic e, input logic s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %b seen %b", what, e, s);
      end
   endtask

   task automatic tally_and_finish;
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(negedge clk_in) begin
      if (tx_start === 1'b1) begin
         starts++;
         check_word("command", {13'h0, exp_cmd}, {13'h0, tx_cmd});
         check_word("decoder", {9'h0, exp_addr}, {9'h0, tx_addr});
      end
      if (des_go === 1'b1) begin
         gos++;
         check_flag("busy at release", 1'b0, busy);
      end
   end

   // ==========================================================
   // Register access; the bound covers a read held back for a whole talkback
   task automatic reg_access(input logic wr, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= ~wr;
      @(negedge clk_in);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      while (ack !== 1'b1) begin
         if (n++ > TMO + 20) begin
            failures++;
            $display("Error bus answer expected ack seen none");
            tally_and_finish();
         end
         @(negedge clk_in);
      end
      q = rdata;
   endtask

   function automatic logic [15:0] model_reply(input logic [2:0] c, input logic [6:0] a);
      logic [15:0] w;
      case (c)
         3'h4: begin
            w = {1'b1, exp_cnt[14:0]};
            exp_cnt = (exp_cnt + 1) % 32768;
         end
         3'h5: w = 16'h0001;
         3'h6: begin
            w = {1'b0, a, 8'(exp_ptr[a])};
            exp_ptr[a]++;
         end
         default: begin
            w = 16'h1801;
            exp_ptr[a] = 0;
         end
      endcase
      return w;
   endfunction

   function automatic logic [3:0] field_of(input int p);
      case (p) inside
         [0:3]: return 4'h0;
         [4:15]: return 4'h1;
         [16:27]: return 4'h2;
         28: return 4'h3;
         [29:30]: return 4'h4;
         [31:32]: return 4'h5;
         33: return 4'h6;
         34: return 4'h7;
         default: return 4'h8;
      endcase
   endfunction

   // One talkback; with extra set, disturbances are injected while it runs
   task automatic talk(input logic [2:0] c, input logic [6:0] a, input logic silent,
         input logic extra);
      logic [15:0] e;
      int s0;
      int g0;
      s0 = starts;
      g0 = gos;
      mute = silent;
      delay = extra ? 8'($urandom_range(30, 60)) : 8'($urandom_range(0, 8));
      exp_cmd = c;
      exp_addr = a;
      reg_access(1'b1, `REG_STATUS, `ZERO16);
      reg_access(1'b1, `REG_TARGET, {5'h00, c, 1'b0, a});
      reg_access(1'b1, `REG_TRIG, `TRIG_ALL_ONES);
      @(negedge clk_in);
      check_flag("busy", 1'b1, busy);
      if (extra) begin
         des_req <= 1'b1;
         @(negedge clk_in);
         des_req <= 1'b0;
         reg_access(1'b1, `REG_TARGET, 16'h0401);
         reg_access(1'b1, `REG_TRIG, `TRIG_ALL_ONES);
      end
      reg_access(1'b0, `REG_TRIG, `ZERO16);
      e = silent ? `RESULT_NONE : model_reply(c, a);
      check_word("result", e, q);
      reg_access(1'b0, `REG_STATUS, `ZERO16);
      check_flag("good reply", ~silent, q[`ST_BIT_GOOD]);
      check_flag("no reply", silent, q[`ST_BIT_NOREPLY]);
      check_flag("busy bit", 1'b0, q[`ST_BIT_BUSY]);
      reg_access(1'b0, `REG_TARGET, `ZERO16);
      check_word("target", {5'h00, c, 1'b0, a}, q);
      check_word("starts", 16'(s0 + 1), 16'(starts));
      check_word("releases", 16'(g0 + int'(extra)), 16'(gos));
   endtask

   initial begin
      void'($urandom(32'h4d87));
      repeat (6) @(negedge clk_in);
      rst_in = 1'b0;
      reg_access(1'b0, `REG_THRESH, `ZERO16);
      check_word("threshold", `THRESH_RESET, q);
      reg_access(1'b0, `REG_TRIG, `ZERO16);
      check_word("trigger", `ZERO16, q);
      reg_access(1'b0, 8'h40, `ZERO16);
      check_word("unmapped", `ZERO16, q);
      des_req <= 1'b1;
      @(negedge clk_in);
      des_req <= 1'b0;
      repeat (2) @(negedge clk_in);
      check_word("idle release", 16'h0001, 16'(gos));
      for (int c = 4; c < 8; c++) begin
         talk(3'(c), 7'd20, 1'b0, 1'b1);
      end
      talk(`CMD_ASK1, 7'd20, 1'b0, 1'b0);
      talk(`CMD_ASK1, 7'd20, 1'b0, 1'b0);
      talk(`CMD_ASK4, 7'd99, 1'b1, 1'b1);
      // The walk never switches the decoder on, which would rewind it
      talk(`CMD_ASK4, 7'd5, 1'b0, 1'b0);
      for (int p = 0; p < 36; p++) begin
         talk(`CMD_ASK3, 7'd5, 1'b0, 1'b0);
         check_word("field", {12'h000, field_of(p + 1)}, {12'h000, pfield});
      end
      reg_access(1'b0, `REG_PTR, `ZERO16);
      check_word("pointer", {6'h00, 4'h8, 6'd36}, q);
      steps[3] = 16'($urandom_range(0, 2000));
      for (int i = 0; i < 4; i++) begin
         step_ma <= steps[i];
         step_v <= 1'b1;
         @(negedge clk_in);
         step_v <= 1'b0;
         reg_access(1'b0, `REG_STEP, `ZERO16);
         check_word("current step", steps[i], q);
         reg_access(1'b0, `REG_STATUS, `ZERO16);
         check_flag("switch fail", steps[i] > `THRESH_RESET, q[`ST_BIT_FAIL]);
      end
      tally_and_finish();
   end
endmodule // tb
